// ### rtl/cifg_gate.v
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "cifg_map.vh"

module cifg_gate (
	// Clock, reset and enable
	input wire aclk,
	input wire aresetn,
	input wire ce,
	// AXI4-Lite write address
	input wire awvalid,
	output wire awready,
	input wire [31:0] awaddr,
	// AXI4-Lite write data
	input wire wvalid,
	output wire wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	// AXI4-Lite write response
	output reg bvalid,
	input wire bready,
	output reg [1:0] bresp,
	// AXI4-Lite read address
	input wire arvalid,
	output wire arready,
	input wire [31:0] araddr,
	// AXI4-Lite read data
	output reg rvalid,
	input wire rready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	// Classification request from the ingress packet processor
	input wire pkt_valid,
	input wire pkt_from_cpu_tag,
	input wire pkt_to_cipher,
	input wire pkt_encrypted,
	// Per-packet gate, held until the next classification
	// Single-bit outputs decode the most used fields of that gate
	output reg pkt_gate_valid,
	output reg [`CIFG_GATE_W-1:0] pkt_gate,
	output reg forwarding_lookup_en,
	output reg pkt_learn_en,
	output reg pkt_drop,
	output reg ignore_host_redirects,
	output reg permit_route,
	output reg pkt_mirror_en,
	output reg reuse_portmask_post_cipher,
	output reg reuse_queue_post_cipher
);

	// ==========================================================
	// Address decode
	// ==========================================================
	// Selector codes, one per reachable register word
	localparam [2:0] SEL_NONE = 3'h0;
	// Gate words
	localparam [2:0] SEL_UNTAG_LO = 3'h1;
	localparam [2:0] SEL_UNTAG_HI = 3'h2;
	localparam [2:0] SEL_TAG_LO = 3'h3;
	localparam [2:0] SEL_TAG_HI = 3'h4;
	// Own counters and status
	localparam [2:0] SEL_DROP_CNT = 3'h5;
	localparam [2:0] SEL_PKT_CNT = 3'h6;
	localparam [2:0] SEL_STATUS = 3'h7;

	// Map a byte address to a register selector; low two bits ignored
	// Used for the held write address and the live read address
	function [2:0] reg_select;
		input [31:0] addr;
		reg [29:0] idx;
		begin
			idx = addr[31:2];
			reg_select = SEL_NONE;
			// Anything not matched answers with an error response
			// Each gate spans its index and the following one
			if (idx == `CIFG_IDX_UNTAG) begin
				reg_select = SEL_UNTAG_LO;
			end else if (idx == `CIFG_IDX_UNTAG + 30'h1) begin
				reg_select = SEL_UNTAG_HI;
			end else if (idx == `CIFG_IDX_TAG) begin
				// Tagged gate, same two-word layout
				reg_select = SEL_TAG_LO;
			end else if (idx == `CIFG_IDX_TAG + 30'h1) begin
				reg_select = SEL_TAG_HI;
			end else if (idx == `CIFG_IDX_DROP_CNT) begin
				// Counters and status sit in their own index range
				reg_select = SEL_DROP_CNT;
			end else if (idx == `CIFG_IDX_PKT_CNT) begin
				reg_select = SEL_PKT_CNT;
			end else if (idx == `CIFG_IDX_STATUS) begin
				reg_select = SEL_STATUS;
			end
		end
	endfunction

	// Merge new data into an old word under the byte strobes
	// Used by both gate lanes for the low and the high word
	function [31:0] strobe_merge;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0] strb;
		integer i;
		begin
			// Lanes with a low strobe keep the old byte
			strobe_merge = old_word;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					strobe_merge[i*8 +: 8] = new_word[i*8 +: 8];
				end
			end
		end
	endfunction

	// ==========================================================
	// Storage
	// ==========================================================
	// Read view of both gates; each is stored in its lane below
	wire [`CIFG_GATE_W-1:0] gate_mem [0:1]; // Index 0 untagged, 1 tagged
	reg [31:0] drop_count; // Forced drops seen here
	reg [31:0] pkt_count; // Packets classified
	reg last_from_tag; // Source of the last classified packet
	// Both halves of a write wait here until both are in
	reg aw_held; // Write address captured
	reg w_held; // Write data captured
	reg [31:0] aw_addr_q; // Captured write address
	reg [31:0] wdata_q; // Captured write data
	reg [3:0] wstrb_q; // Captured write strobes

	// Write happens once both halves are held
	wire wr_fire = ce & aw_held & w_held;
	wire [2:0] wr_sel = reg_select(aw_addr_q);
	wire [2:0] rd_sel = reg_select(araddr);
	wire pkt_take = ce & pkt_valid;
	// Gate chosen for the current packet by its source
	// The tag flag picks the array index directly
	wire [`CIFG_GATE_W-1:0] gate_pick = gate_mem[pkt_from_cpu_tag];

	// Handshake readies; ce low holds everything
	// A pending response blocks new writes and a pending read new reads,
	// so at most one of each is ever in flight
	assign awready = ce & ~aw_held & ~bvalid;
	assign wready = ce & ~w_held & ~bvalid;
	assign arready = ce & ~rvalid;

	// ==========================================================
	// Write channel capture and response
	// ==========================================================
	// Address and data are taken independently, in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			// Nothing pending after reset
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `CIFG_RESP_OKAY;
		end else if (ce) begin
			// Capture address
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= awaddr;
			end
			// Capture data
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			// Commit and answer the edge after both halves are held;
			// an unmapped write changes nothing and answers with an error
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (wr_sel == SEL_NONE) ? `CIFG_RESP_SLVERR : `CIFG_RESP_OKAY;
			end else if (bvalid && bready) begin
				// Response leaves once the master has taken it
				bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Gate registers
	// ==========================================================
	// One lane per gate; low word holds bits 31:0, high word 36:32
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : gate_lane
			// Lane 0 serves untagged packets, lane 1 tagged ones
			reg [`CIFG_GATE_W-1:0] gate_q; // Stored gate of this lane
			wire [2:0] sel_lo = (g == 0) ? SEL_UNTAG_LO : SEL_TAG_LO;
			wire [2:0] sel_hi = (g == 0) ? SEL_UNTAG_HI : SEL_TAG_HI;
			wire [31:0] lo_new = strobe_merge(gate_q[31:0], wdata_q, wstrb_q);
			wire [31:0] hi_old = {27'h0000000, gate_q[`CIFG_GATE_W-1:32]};
			wire [31:0] hi_new = strobe_merge(hi_old, wdata_q, wstrb_q);
			// One writer per lane; the array is only a read view
			assign gate_mem[g] = gate_q;
			// Read/write entry, reset to the power-on enables
			always @(posedge aclk) begin
				if (!aresetn) begin
					gate_q <= `CIFG_GATE_RESET;
				end else if (wr_fire) begin
					if (wr_sel == sel_lo) begin
						// Low word: every strobe lane updates its own byte
						gate_q[31:0] <= lo_new;
					end else if (wr_sel == sel_hi) begin
						// High word: only byte 0 carries field bits
						gate_q[`CIFG_GATE_W-1:32] <= hi_new[`CIFG_HI_W-1:0];
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Counters and status
	// ==========================================================
	// Next values of both counters
	reg [31:0] next_drop_count;
	reg [31:0] next_pkt_count;

	// A packet event in the clearing cycle survives as a count of one
	// Clear is applied first and the event added on top of it
	always @* begin
		next_drop_count = drop_count;
		next_pkt_count = pkt_count;
		if (wr_fire && wr_sel == SEL_DROP_CNT) begin
			next_drop_count = 32'h00000000;
		end
		if (wr_fire && wr_sel == SEL_PKT_CNT) begin
			next_pkt_count = 32'h00000000;
		end
		// Forced drop bumps the drop counter, saturating
		if (pkt_take && gate_pick[`CIFG_B_DROP] && next_drop_count != 32'hffffffff) begin
			next_drop_count = next_drop_count + 32'h00000001;
		end
		// Every classified packet is counted, saturating as well
		if (pkt_take && next_pkt_count != 32'hffffffff) begin
			next_pkt_count = next_pkt_count + 32'h00000001;
		end
	end

	// Counter and status flops
	always @(posedge aclk) begin
		if (!aresetn) begin
			// Counters start at zero
			drop_count <= 32'h00000000;
			pkt_count <= 32'h00000000;
			last_from_tag <= 1'b0;
		end else if (ce) begin
			drop_count <= next_drop_count;
			pkt_count <= next_pkt_count;
			// Status keeps the source of the most recent packet
			if (pkt_take) begin
				last_from_tag <= pkt_from_cpu_tag;
			end
		end
	end

	// ==========================================================
	// Read channel
	// ==========================================================
	reg [31:0] rd_word;

	// Read mux; unused upper bits read as zero
	// The selector follows the live address and the word is captured
	// at the same edge that accepts that address
	always @* begin
		case (rd_sel)
			SEL_UNTAG_LO: rd_word = gate_mem[0][31:0];
			SEL_UNTAG_HI: rd_word = {27'h0000000, gate_mem[0][`CIFG_GATE_W-1:32]};
			SEL_TAG_LO: rd_word = gate_mem[1][31:0];
			SEL_TAG_HI: rd_word = {27'h0000000, gate_mem[1][`CIFG_GATE_W-1:32]};
			// Counters read as full words
			SEL_DROP_CNT: rd_word = drop_count;
			SEL_PKT_CNT: rd_word = pkt_count;
			SEL_STATUS: rd_word = {31'h00000000, last_from_tag};
			default: rd_word = 32'h00000000;
		endcase
	end

	// Answer one cycle after the address is taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			// No read pending after reset
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `CIFG_RESP_OKAY;
		end else if (ce) begin
			// Unmapped reads answer zero with an error
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= rd_word;
				rresp <= (rd_sel == SEL_NONE) ? `CIFG_RESP_SLVERR : `CIFG_RESP_OKAY;
			end else if (rvalid && rready) begin
				// Data leaves once the master has taken it
				rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Per-packet classification
	// ==========================================================
	// The gate is latched once per packet so a later software write
	// cannot change the treatment of a packet already in flight.
	always @(posedge aclk) begin
		if (!aresetn) begin
			// Outputs start from the reset gate so that later stages
			// see the power-on enables before the first packet
			pkt_gate_valid <= 1'b0;
			pkt_gate <= `CIFG_GATE_RESET;
			forwarding_lookup_en <= 1'b1;
			pkt_learn_en <= 1'b1;
			pkt_drop <= 1'b0;
			ignore_host_redirects <= 1'b0;
			permit_route <= 1'b1;
			pkt_mirror_en <= 1'b1;
			reuse_portmask_post_cipher <= 1'b0;
			reuse_queue_post_cipher <= 1'b0;
		end else if (ce) begin
			// One-cycle valid pulse per classified packet
			pkt_gate_valid <= pkt_valid;
			// Without a request every other output keeps its value
			if (pkt_valid) begin
				// Whole vector feeds the other pipeline stages
				pkt_gate <= gate_pick;
				// Lookup enable
				forwarding_lookup_en <= gate_pick[`CIFG_B_LOOKUP];
				// Learning is on unless suppressed
				pkt_learn_en <= ~gate_pick[`CIFG_B_NO_LEARN];
				// Forced discard
				pkt_drop <= gate_pick[`CIFG_B_DROP];
				// Decoder send-to-CPU actions ignored
				ignore_host_redirects <= gate_pick[`CIFG_B_IGNORE_REDIR];
				// Routing permission
				permit_route <= gate_pick[`CIFG_B_ROUTE];
				// Flags below also depend on this packet's own path
				// Mirroring, blocked for cipher-bound packets when asked
				pkt_mirror_en <= gate_pick[`CIFG_B_MIRROR] &
					~(pkt_to_cipher & gate_pick[`CIFG_B_CIPHER_NOMIR]);
				// Reuse of earlier choices once encrypted
				reuse_portmask_post_cipher <= pkt_encrypted & gate_pick[`CIFG_B_REUSE_PM];
				reuse_queue_post_cipher <= pkt_encrypted & gate_pick[`CIFG_B_REUSE_Q];
			end
		end
	end

endmodule

`default_nettype wire

// ### rtl/cifg_map.vh
`ifndef CIFG_MAP_VH
`define CIFG_MAP_VH

// ==========================================================
// Register indices (word index; byte address is four times)
// ==========================================================
// Gate for CPU-port packets without a from-CPU tag
`define CIFG_IDX_UNTAG 30'h001120a3
// Gate for CPU-port packets carrying a from-CPU tag
`define CIFG_IDX_TAG 30'h001120ad
// Functional-control drop counter, clear on write
`define CIFG_IDX_DROP_CNT 30'h00112100
// Count of packets classified through this block, clear on write
`define CIFG_IDX_PKT_CNT 30'h00112101
// Status: bit 0 is the source of the last classified packet
`define CIFG_IDX_STATUS 30'h00112102

// ==========================================================
// Gate layout and reset value
// ==========================================================
`define CIFG_GATE_W 37
`define CIFG_HI_W 5
`define CIFG_GATE_RESET 37'h1ffffffff1

// ==========================================================
// Field positions inside a gate register
// ==========================================================
`define CIFG_B_LOOKUP 0
`define CIFG_B_NO_LEARN 1
`define CIFG_B_DROP 2
`define CIFG_B_IGNORE_REDIR 3
`define CIFG_B_ROUTE 4
`define CIFG_B_RSV_DMAC 5
`define CIFG_B_RSV_SMAC 6
`define CIFG_B_SRC_TAG_OPS 7
`define CIFG_B_TUNNEL 8
`define CIFG_B_SMON 9
`define CIFG_B_RX_FILTER 10
`define CIFG_B_RX_ACL 11
`define CIFG_B_RX_STP 12
`define CIFG_B_TX_STP 13
`define CIFG_B_MEMBER_DROP 14
`define CIFG_B_VID_OPS 15
`define CIFG_B_RX_MSTP 16
`define CIFG_B_TX_MSTP 17
`define CIFG_B_HDR_SUM 18
`define CIFG_B_L2_ACTION 19
`define CIFG_B_STATION_MOVE 20
`define CIFG_B_POLICER 21
`define CIFG_B_VRF_CNT 22
`define CIFG_B_NH_HIT 23
`define CIFG_B_ROUTED_EDIT 24
`define CIFG_B_TX_ACL 25
`define CIFG_B_RX_XLATE 26
`define CIFG_B_TX_XLATE 27
`define CIFG_B_XLATE_ACT 28
`define CIFG_B_MBSC 29
`define CIFG_B_MIRROR 30
`define CIFG_B_QUEUE_CHECK 31
`define CIFG_B_PORT_CNT 32
`define CIFG_B_REUSE_PM 33
`define CIFG_B_REUSE_Q 34
`define CIFG_B_CIPHER_NOMIR 35
`define CIFG_B_RXTX_FILTER 36

// ==========================================================
// Bus answers
// ==========================================================
`define CIFG_RESP_OKAY 2'h0
`define CIFG_RESP_SLVERR 2'h2

`endif

// ### verification/cifg_gate_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Checker for the per-packet gate outputs
module cifg_gate_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Packet request
	input wire logic ce,
	input wire logic pkt_valid,
	input wire logic pkt_to_cipher,
	input wire logic pkt_encrypted,
	// Packet answer
	input wire logic pkt_gate_valid,
	input wire logic [36:0] pkt_gate,
	input wire logic forwarding_lookup_en,
	input wire logic pkt_learn_en,
	input wire logic pkt_drop,
	input wire logic ignore_host_redirects,
	input wire logic permit_route,
	input wire logic pkt_mirror_en,
	input wire logic reuse_portmask_post_cipher,
	input wire logic reuse_queue_post_cipher
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Request taken at an enabled edge
	sequence s_take;
		ce && pkt_valid;
	endsequence
	// Enabled edge without a request
	sequence s_idle;
		ce && !pkt_valid;
	endsequence
	property p_pulse; s_take |=> pkt_gate_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("no gate pulse");
	property p_quiet; s_idle |=> !pkt_gate_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("stray gate pulse");
	property p_hold; aresetn && !(ce && pkt_valid) |=> $stable(pkt_gate); endproperty
	a_hold: assert property (p_hold) else $error("gate moved");
	property p_look; forwarding_lookup_en == pkt_gate[0] && permit_route == pkt_gate[4]; endproperty
	a_look: assert property (p_look) else $error("lookup or route wrong");
	property p_learn; pkt_learn_en == !pkt_gate[1]; endproperty
	a_learn: assert property (p_learn) else $error("learn wrong");
	property p_drop; pkt_drop == pkt_gate[2] && ignore_host_redirects == pkt_gate[3]; endproperty
	a_drop: assert property (p_drop) else $error("drop or redirect wrong");
	property p_mir;
		s_take |=> pkt_mirror_en == (pkt_gate[30] && !($past(pkt_to_cipher) && pkt_gate[35]));
	endproperty
	a_mir: assert property (p_mir) else $error("mirror wrong");
	property p_reuse;
		s_take |=> reuse_portmask_post_cipher == ($past(pkt_encrypted) && pkt_gate[33])
			&& reuse_queue_post_cipher == ($past(pkt_encrypted) && pkt_gate[34]);
	endproperty
	a_reuse: assert property (p_reuse) else $error("reuse wrong");
endmodule
`default_nettype wire

// ### verification/cifg_gate_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cifg_map.vh"
// ==========================================================
// Bench for the CPU ingress gate block
module cifg_gate_tb_top;
	// Byte addresses and answers
	localparam logic [31:0] a_unt = {`CIFG_IDX_UNTAG, 2'b00};
	localparam logic [31:0] a_tag = {`CIFG_IDX_TAG, 2'b00};
	localparam logic [31:0] a_drp = {`CIFG_IDX_DROP_CNT, 2'b00};
	localparam logic [31:0] a_pkt = {`CIFG_IDX_PKT_CNT, 2'b00};
	localparam logic [31:0] a_sts = {`CIFG_IDX_STATUS, 2'b00};
	localparam logic [1:0] ok = `CIFG_RESP_OKAY;
	localparam logic [1:0] er = `CIFG_RESP_SLVERR;
	// Inputs and outputs
	logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic pkt_valid, pkt_from_cpu_tag, pkt_to_cipher, pkt_encrypted;
	logic awready, wready, bvalid, arready, rvalid, pkt_gate_valid;
	logic [1:0] bresp, rresp;
	logic [36:0] pkt_gate, gr, gu, gt;
	logic forwarding_lookup_en, pkt_learn_en, pkt_drop, ignore_host_redirects;
	logic permit_route, pkt_mirror_en, reuse_portmask_post_cipher, reuse_queue_post_cipher;
	int mismatches, checks;
	cifg_gate DUT (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .pkt_valid, .pkt_from_cpu_tag, .pkt_to_cipher,
		.pkt_encrypted, .pkt_gate_valid, .pkt_gate, .forwarding_lookup_en, .pkt_learn_en,
		.pkt_drop, .ignore_host_redirects, .permit_route, .pkt_mirror_en,
		.reuse_portmask_post_cipher, .reuse_queue_post_cipher);
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [63:0] g, e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic close_out;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Hang cut short
	task automatic stall;
		mismatches++;
		close_out;
	endtask
	// Bus write, address and data offered together
	task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] r);
		logic ta, tw, tb;
		tb = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 40 && !tb; n++) begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			if (tb) chk(bresp, r);
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (!tb) stall;
	endtask
	// Bus read
	task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
		logic ta, tk;
		tk = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 40 && !tk; n++) begin
			@(negedge aclk);
			ta = arvalid && arready;
			tk = rvalid;
			if (tk) chk({rresp, rdata}, {r, d});
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		if (!tk) stall;
	endtask
	// One packet classified against expected gate g
	task automatic pk(input logic t, c, e, input logic [36:0] g);
		@(posedge aclk);
		pkt_valid <= 1'b1;
		pkt_from_cpu_tag <= t;
		pkt_to_cipher <= c;
		pkt_encrypted <= e;
		@(posedge aclk);
		pkt_valid <= 1'b0;
		@(negedge aclk);
		chk({pkt_gate_valid, pkt_gate}, {1'b1, g});
		chk({forwarding_lookup_en, pkt_learn_en, pkt_drop}, {g[0], !g[1], g[2]});
		chk({ignore_host_redirects, permit_route}, {g[3], g[4]});
		chk(pkt_mirror_en, g[30] && !(c && g[35]));
		chk({reuse_portmask_post_cipher, reuse_queue_post_cipher}, {e && g[33], e && g[34]});
	endtask
	// ==========================================================
	// Clock and main sequence
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr, wstrb} = '0;
		{pkt_valid, pkt_from_cpu_tag, pkt_to_cipher, pkt_encrypted} = '0;
		ce = 1'b1;
		mismatches = 0;
		checks = 0;
		gr = `CIFG_GATE_RESET;
		gu = 37'h15_5a5a_a5a4;
		gt = 37'h0a_c3c3_3c3b;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			rd(i ? a_tag : a_unt, gr[31:0], ok);
			rd((i ? a_tag : a_unt) + 32'h4, {27'h0, gr[36:32]}, ok);
		end
		pk(1'b0, 1'b1, 1'b1, gr);
		wr(a_unt, gu[31:0], 4'hf, ok);
		wr(a_unt + 32'h4, {27'h7ffffff, gu[36:32]}, 4'hf, ok);
		wr(a_tag, gt[31:0], 4'hf, ok);
		wr(a_tag + 32'h4, {27'h0, gt[36:32]}, 4'hf, ok);
		wr(a_unt + 32'h8, 32'hffffffff, 4'hf, er);
		rd(a_unt + 32'h8, 32'h0, er);
		rd(a_unt + 32'h4, {27'h0, gu[36:32]}, ok);
		rd(a_tag, gt[31:0], ok);
		pk(1'b0, 1'b1, 1'b0, gu);
		pk(1'b1, 1'b1, 1'b1, gt);
		pk(1'b0, 1'b0, 1'b1, gu);
		rd(a_drp, 32'h2, ok);
		rd(a_pkt, 32'h4, ok);
		rd(a_sts, 32'h0, ok);
		wr(a_drp, 32'h0, 4'hf, ok);
		rd(a_drp, 32'h0, ok);
		wr(a_tag, 32'h0, 4'h1, ok);
		gt[7:0] = 8'h00;
		rd(a_tag, gt[31:0], ok);
		pk(1'b1, 1'b0, 1'b0, gt);
		rd(a_sts, 32'h1, ok);
		// Clock enable low: requests refused, state frozen
		@(posedge aclk);
		ce <= 1'b0;
		pkt_valid <= 1'b1;
		@(posedge aclk);
		@(negedge aclk);
		chk({awready, wready, arready, pkt_gate_valid}, 4'h0);
		chk(pkt_gate, gt);
		@(posedge aclk);
		ce <= 1'b1;
		pkt_valid <= 1'b0;
		rd(a_pkt, 32'h5, ok);
		// Second reset in mid-run brings the gates back to their defaults
		@(posedge aclk);
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk({pkt_gate_valid, pkt_gate}, {1'b0, gr});
		rd(a_tag, gr[31:0], ok);
		rd(a_pkt, 32'h0, ok);
		close_out;
	end
endmodule
bind cifg_gate cifg_gate_checker u_chk (.aclk, .aresetn, .ce, .pkt_valid, .pkt_to_cipher,
	.pkt_encrypted, .pkt_gate_valid, .pkt_gate, .forwarding_lookup_en, .pkt_learn_en,
	.pkt_drop, .ignore_host_redirects, .permit_route, .pkt_mirror_en,
	.reuse_portmask_post_cipher, .reuse_queue_post_cipher);
`default_nettype wire
